//--- rtl/rhf_pkg.sv
// Package for the receive hash filter and receive-queue watermarks.
// Assumes a 16-bit register port with byte addresses as printed.
package rhf_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_HASH0 = 8'ha0;
  localparam logic [7:0] ADDR_HASH1 = 8'ha2;
  localparam logic [7:0] ADDR_HASH2 = 8'ha4;
  localparam logic [7:0] ADDR_HASH3 = 8'ha6;
  localparam logic [7:0] ADDR_LOW_WM = 8'hb0;
  localparam logic [7:0] ADDR_HIGH_WM = 8'hb2;
  localparam logic [7:0] ADDR_OVR_WM = 8'hb4;
  // Reset values
  localparam logic [15:0] RST_HASH = 16'h0000;
  localparam logic [11:0] RST_LOW_WM = 12'h500;
  localparam logic [11:0] RST_HIGH_WM = 12'h300;
  localparam logic [11:0] RST_OVR_WM = 12'h040;
  // Field layout
  localparam int WM_WIDTH = 12;
  localparam int HASH_SEL_MSB = 5;
  localparam int HASH_SEL_LSB = 4;
  localparam int HASH_BIT_MSB = 3;
  // Receive queue size in double words: 12 KByte
  localparam logic [11:0] RXQ_TOTAL_DW = 12'hc00;
  // CRC-32 over the destination address
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam int DA_BITS = 48;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } rhf_reg_req_s;

  typedef struct packed {
    logic valid;
    logic [47:0] dest_addr;
    logic is_multicast;
    logic hash_perfect_mode;
  } rhf_frame_s;
endpackage

//--- rtl/rhf_crc_hash.sv
// Hash index from the CRC over a 48-bit destination address.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
module rhf_crc_hash (
  // Address in
  input wire logic [47:0] dest_addr,
  // Six-bit index out
  output logic [5:0] hash_index
);
  function automatic logic [31:0] crc_bit(input logic [31:0] c,
                                          input logic d);
    logic fb;
    fb = c[31] ^ d;
    crc_bit = {c[30:0], 1'b0} ^ (fb ? rhf_pkg::CRC_POLY : 32'h00000000);
  endfunction

  logic [31:0] crc;
  always_comb
  begin
    crc = rhf_pkg::CRC_INIT;
    // Bits go in wire order: each byte least significant bit first
    for (int i = 0; i < rhf_pkg::DA_BITS; i++)
    begin
      crc = crc_bit(crc, dest_addr[i]);
    end
  end

  assign hash_index = crc[31:26];
endmodule // rhf_crc_hash

//--- rtl/rhf_filter_top.sv
// Multicast hash table, hash-filter decision and receive-queue watermark
// flow control. Registers sit on a 16-bit word port at printed offsets.
// Assumes the queue manager reports free space in double words.
`timescale 1ns/1ps
module rhf_filter_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire rhf_pkg::rhf_reg_req_s reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Receive control bits
  input wire logic receive_everything_enable,
  input wire logic receive_all_multicast_enable,
  // Frame under decision
  input wire rhf_pkg::rhf_frame_s frame,
  output logic frame_done,
  output logic frame_accept,
  // Queue manager free space, double words
  input wire logic [11:0] rxq_free_dw,
  output logic flow_ctrl_active,
  output logic overrun_imminent
);
  logic rst_s1, rst_sync_n;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  logic [15:0] hash_bits_word0, hash_bits_word1;
  logic [15:0] hash_bits_word2, hash_bits_word3;
  logic [11:0] low_mark_level, high_mark_level, overrun_mark_level;

  wire wr_h0 = reg_req.wr && reg_req.addr == rhf_pkg::ADDR_HASH0;
  wire wr_h1 = reg_req.wr && reg_req.addr == rhf_pkg::ADDR_HASH1;
  wire wr_h2 = reg_req.wr && reg_req.addr == rhf_pkg::ADDR_HASH2;
  wire wr_h3 = reg_req.wr && reg_req.addr == rhf_pkg::ADDR_HASH3;
  wire wr_lo = reg_req.wr && reg_req.addr == rhf_pkg::ADDR_LOW_WM;
  wire wr_hi = reg_req.wr && reg_req.addr == rhf_pkg::ADDR_HIGH_WM;
  wire wr_ov = reg_req.wr && reg_req.addr == rhf_pkg::ADDR_OVR_WM;

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      hash_bits_word0 <= rhf_pkg::RST_HASH;
      hash_bits_word1 <= rhf_pkg::RST_HASH;
      hash_bits_word2 <= rhf_pkg::RST_HASH;
      hash_bits_word3 <= rhf_pkg::RST_HASH;
      low_mark_level <= rhf_pkg::RST_LOW_WM;
      high_mark_level <= rhf_pkg::RST_HIGH_WM;
      overrun_mark_level <= rhf_pkg::RST_OVR_WM;
    end
    else if (clk_en)
    begin
      if (wr_h0) hash_bits_word0 <= reg_req.wdata;
      if (wr_h1) hash_bits_word1 <= reg_req.wdata;
      if (wr_h2) hash_bits_word2 <= reg_req.wdata;
      if (wr_h3) hash_bits_word3 <= reg_req.wdata;
      // Upper nibble is simply not stored
      if (wr_lo) low_mark_level <= reg_req.wdata[11:0];
      if (wr_hi) high_mark_level <= reg_req.wdata[11:0];
      if (wr_ov) overrun_mark_level <= reg_req.wdata[11:0];
    end
  end

  // Read mux; unmapped offsets read zero
  logic [15:0] rd_mux;
  assign rd_mux =
    (reg_req.addr == rhf_pkg::ADDR_HASH0) ? hash_bits_word0 :
    (reg_req.addr == rhf_pkg::ADDR_HASH1) ? hash_bits_word1 :
    (reg_req.addr == rhf_pkg::ADDR_HASH2) ? hash_bits_word2 :
    (reg_req.addr == rhf_pkg::ADDR_HASH3) ? hash_bits_word3 :
    (reg_req.addr == rhf_pkg::ADDR_LOW_WM) ? {4'h0, low_mark_level} :
    (reg_req.addr == rhf_pkg::ADDR_HIGH_WM) ? {4'h0, high_mark_level} :
    (reg_req.addr == rhf_pkg::ADDR_OVR_WM) ? {4'h0, overrun_mark_level} :
    16'h0000;

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) reg_rdata <= rd_mux;
    end
  end

  // Hash lookup
  logic [5:0] hash_index;
  rhf_crc_hash u_hash (
    .dest_addr(frame.dest_addr),
    .hash_index(hash_index)
  );

  logic [15:0] sel_word;
  assign sel_word =
    (hash_index[5:4] == 2'h0) ? hash_bits_word0 :
    (hash_index[5:4] == 2'h1) ? hash_bits_word1 :
    (hash_index[5:4] == 2'h2) ? hash_bits_word2 :
    hash_bits_word3;
  wire table_hit = sel_word[hash_index[3:0]];
  wire mc_pass_all = receive_everything_enable |
                     receive_all_multicast_enable;
  // Outside hash-perfect mode, or for non-multicast, this filter passes
  wire next_accept = !frame.is_multicast || !frame.hash_perfect_mode ||
                     mc_pass_all || table_hit;

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      frame_done <= 1'b0;
      frame_accept <= 1'b0;
    end
    else if (clk_en)
    begin
      frame_done <= frame.valid;
      if (frame.valid) frame_accept <= next_accept;
    end
  end

  // Free space, not fill level, is compared; hysteresis between marks
  wire below_high = rxq_free_dw < high_mark_level;
  wire above_low = rxq_free_dw > low_mark_level;
  wire below_ovr = rxq_free_dw < overrun_mark_level;
  wire next_fc = below_high ? 1'b1 : (above_low ? 1'b0 : flow_ctrl_active);

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      flow_ctrl_active <= 1'b0;
      overrun_imminent <= 1'b0;
    end
    else if (clk_en)
    begin
      flow_ctrl_active <= next_fc;
      overrun_imminent <= below_ovr;
    end
  end

  // Checks
  hash_drop_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && frame.valid && frame.is_multicast && frame.hash_perfect_mode
    && !mc_pass_all && !table_hit |=> frame_done && !frame_accept)
    else $error("hashed miss not dropped");
  hash_accept_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && frame.valid && frame.is_multicast && table_hit
    |=> frame_accept)
    else $error("hashed hit not accepted");
  pass_all_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && frame.valid && mc_pass_all |=> frame_accept)
    else $error("pass-all multicast dropped");
  mode_gate_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && frame.valid && !frame.hash_perfect_mode |=> frame_accept)
    else $error("table used outside hash mode");
  word_pick_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    hash_index[5:4] == 2'h2 |-> table_hit == hash_bits_word2[hash_index[3:0]])
    else $error("wrong table word chosen");
  wm_upper_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    reg_rvalid && $past(reg_req.addr) == rhf_pkg::ADDR_LOW_WM
    |-> reg_rdata[15:12] == 4'h0)
    else $error("watermark upper bits nonzero");
  fc_start_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && rxq_free_dw < high_mark_level |=> flow_ctrl_active)
    else $error("flow control not started");
  fc_stop_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && rxq_free_dw > low_mark_level && rxq_free_dw >= high_mark_level
    |=> !flow_ctrl_active)
    else $error("flow control not stopped");
  ovr_flag_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && rxq_free_dw < overrun_mark_level |=> overrun_imminent)
    else $error("overrun level missed");
  // Between the marks the flag must keep its last value
  fc_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && rxq_free_dw >= high_mark_level && rxq_free_dw <= low_mark_level
    |=> flow_ctrl_active == $past(flow_ctrl_active))
    else $error("flow control not held between marks");
  ovr_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && rxq_free_dw >= overrun_mark_level |=> !overrun_imminent)
    else $error("overrun flag set above its level");
  hash_store_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && wr_h3 |=> hash_bits_word3 == $past(reg_req.wdata))
    else $error("table word write lost");
  wm_store_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && wr_lo |=> low_mark_level == $past(reg_req.wdata[11:0]))
    else $error("low watermark write lost");
  table_freeze_a: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    !clk_en |=> $stable({hash_bits_word0, hash_bits_word1,
                         hash_bits_word2, hash_bits_word3}))
    else $error("table changed while clock enable low");
endmodule // rhf_filter_top

//--- tb/rhf_link_model.sv
// Link-side model: presents received frames and queue free space.
// Assumes the bench clock; changes its outputs on rising edges only.
`timescale 1ns/1ps
module rhf_link_model (
  // Clock
  input wire logic clk_sys,
  // Toward the filter
  output rhf_pkg::rhf_frame_s frame,
  output logic [11:0] rxq_free_dw
);
  initial frame = '0;
  initial rxq_free_dw = rhf_pkg::RXQ_TOTAL_DW;
  task automatic send(input logic [47:0] da, input logic mc, input logic hm);
    @(posedge clk_sys);
    frame <= '{1'b1, da, mc, hm};
    @(posedge clk_sys);
    // Stale address is inverted, so a late sample cannot pass by luck
    frame <= '{1'b0, ~da, 1'b0, 1'b0};
  endtask
  task automatic set_free(input logic [11:0] v);
    @(posedge clk_sys);
    rxq_free_dw <= v;
  endtask
endmodule // rhf_link_model

//--- tb/rx_hash_filter_watermarks_tb_top.sv
// Self-checking bench for the hash filter and watermark registers.
// Assumes the package, design and link model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module rx_hash_filter_watermarks_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic receive_everything_enable = 1'b0;
  logic receive_all_multicast_enable = 1'b0;
  rhf_pkg::rhf_reg_req_s reg_req = '0;
  rhf_pkg::rhf_frame_s frame;
  logic [11:0] rxq_free_dw;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic frame_done;
  logic frame_accept;
  logic flow_ctrl_active;
  logic overrun_imminent;
  int err_total = 0;
  int checks_done = 0;
  logic [5:0] idx;
  logic [47:0] da = 48'h3300_0000_0001;
  logic [7:0] addrs [7] = '{rhf_pkg::ADDR_HASH0, rhf_pkg::ADDR_HASH1,
    rhf_pkg::ADDR_HASH2, rhf_pkg::ADDR_HASH3, rhf_pkg::ADDR_LOW_WM,
    rhf_pkg::ADDR_HIGH_WM, rhf_pkg::ADDR_OVR_WM};
  logic [15:0] rsts [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0500, 16'h0300, 16'h0040};

  always #25 clk_sys = ~clk_sys;

  rhf_filter_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .receive_everything_enable(receive_everything_enable),
    .receive_all_multicast_enable(receive_all_multicast_enable),
    .frame(frame), .frame_done(frame_done), .frame_accept(frame_accept),
    .rxq_free_dw(rxq_free_dw), .flow_ctrl_active(flow_ctrl_active),
    .overrun_imminent(overrun_imminent));
  rhf_link_model link (.clk_sys(clk_sys), .frame(frame),
    .rxq_free_dw(rxq_free_dw));

  // Serial CRC, first wire bit is address bit 0
  function automatic logic [5:0] hash_of(input logic [47:0] a);
    logic [31:0] c;
    c = rhf_pkg::CRC_INIT;
    for (int i = 0; i < 48; i++)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ a[i]) ? rhf_pkg::CRC_POLY : 32'h0);
    return c[31:26];
  endfunction

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
    `CHK({reg_rvalid, reg_rdata}, {1'b1, e})
  endtask
  task automatic fr(input logic hm, input logic e);
    link.send(da, 1'b1, hm);
    #1;
    `CHK({frame_done, frame_accept}, {1'b1, e})
  endtask
  task automatic fl(input logic [11:0] v, input logic [1:0] e);
    link.set_free(v);
    @(posedge clk_sys);
    #1;
    `CHK({flow_ctrl_active, overrun_imminent}, e)
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 7; i++)
      rd(addrs[i], rsts[i]);
    // A write while the clock enable is low must not land
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(addrs[0], 16'h5555);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(addrs[0], 16'h0000);
    for (int i = 0; i < 7; i++)
    begin
      wr(addrs[i], 16'hffff);
      rd(addrs[i], (i < 4) ? 16'hffff : 16'h0fff);
      wr(addrs[i], rsts[i]);
    end
    wr(8'ha8, 16'h1234);
    rd(8'ha8, 16'h0000);
    idx = hash_of(da);
    fr(1'b1, 1'b0);
    wr(addrs[idx[5:4]], 16'h0001 << idx[3:0]);
    fr(1'b1, 1'b1);
    wr(addrs[idx[5:4]], 16'h0001 << (idx[3:0] ^ 4'h1));
    fr(1'b1, 1'b0);
    // Unicast is not judged by the table even on a miss
    link.send(da, 1'b0, 1'b1);
    #1;
    `CHK({frame_done, frame_accept}, 2'b11)
    receive_everything_enable <= 1'b1;
    fr(1'b1, 1'b1);
    receive_everything_enable <= 1'b0;
    receive_all_multicast_enable <= 1'b1;
    fr(1'b1, 1'b1);
    receive_all_multicast_enable <= 1'b0;
    fr(1'b0, 1'b1);
    // Mid-run reset must bring back every default after the writes
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 7; i++)
      rd(addrs[i], rsts[i]);
    fl(12'h2ff, 2'b10);
    fl(12'h500, 2'b10);
    fl(12'h501, 2'b00);
    fl(12'h03f, 2'b11);
    fl(12'h040, 2'b10);
    summarize();
  end

  // Whole sequence needs under 130 cycles
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
endmodule // rx_hash_filter_watermarks_tb_top
